// ==== hpi_defs.vh ====
// Constants for the host port interface block
`ifndef HPI_DEFS_VH
`define HPI_DEFS_VH
`define HPI_CFG_ENA 0
`define HPI_CFG_PAGE_RESTRICT_ENABLE 1
`define HPI_CFG_NONMUX_SELECT 2
`define HPI_CFG_FULL 3
`define HPI_CFG_BYTE_ADDRESSING_SELECT 4
`define HPI_CTL_HCTL 2'b00
`define HPI_CTL_DATA_INC 2'b01
`define HPI_CTL_ADDR 2'b10
`define HPI_CTL_DATA 2'b11
`define HPI_PORT_CONTROL_REG_DSPINT 1
`define HPI_PORT_CONTROL_REG_TO_HOST_INTERRUPT 2
`define HPI_FIFO_WIDTH 66
`define HPI_FIFO_DEPTH 4
`define HPI_ADDR_RST 32'h0000_0000
`define HPI_DATA_RST 32'h0000_0000
`endif

// ==== hpi_fifo.v ====
// Small synchronous FIFO for the write path of the host port
`timescale 1ns/1ps
`default_nettype none
module hpi_fifo #(
    parameter WIDTH = 66,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire core_clk_in,
    input wire reset_n_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    // Honest flags from the occupancy count
    assign in_ready_out = (count_r != DEPTH);
    assign out_valid_out = (count_r != {(AW+1){1'b0}});
    assign out_data_out = mem_r[rd_ptr_r];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    // Pointers and count
    always @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            if (push & ~pop)
                count_r <= count_r + 1'b1;
            else if (pop & ~push)
                count_r <= count_r - 1'b1;
        end
    end

    // Storage carries no reset
    always @(posedge core_clk_in) begin
        if (push)
            mem_r[wr_ptr_r] <= in_data_in;
    end
endmodule
`default_nettype wire

// ==== hpi_host_port.v ====
// Host port interface: strobe decode, access registers and internal bus master
`include "hpi_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module hpi_host_port (
    input wire core_clk_in,
    input wire reset_n_in,
    input wire [7:0] port_config_reg_in,
    input wire [7:0] page_addr_top_byte_in,
    input wire [7:0] page_addr_upper_mid_byte_in,
    input wire upper_gpio_select_in,
    input wire to_host_interrupt_set_in,
    output wire dsp_interrupt_out,
    input wire host_chip_select_n_in,
    input wire [1:0] host_data_strobes_n_in,
    input wire host_rw_in,
    input wire host_addr_phase_n_in,
    input wire [1:0] access_type_select_in,
    input wire halfword_select_in,
    input wire [3:0] host_byte_enables_n_in,
    input wire [15:0] host_address_lines_in,
    input wire [31:0] host_data_bus_in,
    output reg [31:0] host_data_bus_out,
    output wire [31:0] host_data_bus_oe_out,
    output wire host_ready_n_out,
    output wire to_host_interrupt_n_out,
    output wire mem_req_out,
    output wire mem_write_out,
    output wire [31:0] mem_addr_out,
    output wire [31:0] mem_wdata_out,
    output wire [3:0] mem_be_out,
    input wire mem_ack_in,
    input wire [31:0] mem_rdata_in
);
    localparam ST_IDLE = 2'd0;
    localparam ST_BUSY = 2'd1;
    localparam ST_DONE = 2'd2;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg strobe_q_r;
    reg [1:0] type_r;
    reg hw_r;
    reg rd_r;
    reg [3:0] be_r;
    reg [15:0] ha_r;
    reg [31:0] addr_r;
    reg [31:0] wdata_r;
    reg [31:0] rdata_r;
    reg [2:0] port_control_reg_r;
    reg rd_pending_r;
    reg [31:0] rd_addr_r;
    reg taken_r;
    reg fetched_r;
    wire finish;
    wire half;
    wire wr_need;
    wire rd_hit;
    wire rd_ok;
    wire [31:0] word_addr;
    wire [31:0] mux_byte;
    wire [31:0] nm_byte;
    wire ena;
    wire nonmux_select;
    wire full;
    wire page_restrict_enable;
    wire byte_addressing_select;
    wire strobe;
    wire fall;
    wire rise;
    wire data_acc;
    wire legal;
    wire [31:0] eff_addr;
    wire [31:0] next_addr;
    wire [65:0] fifo_in;
    wire [65:0] fifo_out;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_pop;
    wire wr_push;
    wire [31:0] wr_addr;
    wire [3:0] rd_be;
    wire [15:0] page;

    // Mode bits
    assign ena = port_config_reg_in[`HPI_CFG_ENA];
    assign nonmux_select = port_config_reg_in[`HPI_CFG_NONMUX_SELECT];
    assign full = port_config_reg_in[`HPI_CFG_FULL];
    assign page_restrict_enable = port_config_reg_in[`HPI_CFG_PAGE_RESTRICT_ENABLE] & ~nonmux_select;
    assign byte_addressing_select = port_config_reg_in[`HPI_CFG_BYTE_ADDRESSING_SELECT];
    assign page = {page_addr_top_byte_in, page_addr_upper_mid_byte_in};

    // Strobe is chip select qualified by the xor of the two strobes
    assign strobe = ena & ~host_chip_select_n_in &
        (host_data_strobes_n_in[1] ^ host_data_strobes_n_in[0]) == 1'b0 ?
        1'b0 : ena & ~host_chip_select_n_in;
    // Fall taken only when idle, so a strobe arriving while busy waits its turn
    assign fall = strobe & ~taken_r & (state_r == ST_IDLE);
    assign rise = ~strobe & strobe_q_r & taken_r;
    assign data_acc = type_r[0];
    // Non-mux refuses address and incrementing data types
    assign legal = ~nonmux_select | (type_r == `HPI_CTL_HCTL) | (type_r == `HPI_CTL_DATA);

    // Word or byte address to a byte address
    function [31:0] hpi_to_byte;
        input [31:0] a;
        input byte_mode;
        begin
            hpi_to_byte = byte_mode ? a : {a[29:0], 2'b00};
        end
    endfunction

    // Effective target: page override or 64K non-mux page
    assign mux_byte = hpi_to_byte(addr_r, byte_addressing_select);
    assign nm_byte = hpi_to_byte({16'h0000, ha_r}, byte_addressing_select);
    assign eff_addr = nonmux_select ? {page, nm_byte[15:0]}
        : page_restrict_enable ? {page, mux_byte[15:0]} : mux_byte;
    assign next_addr = addr_r + (byte_addressing_select ? 32'h0000_0004 : 32'h0000_0001);
    assign rd_be = hw_r ? 4'b1111 : be_r;

    // Write path buffered through the FIFO; full FIFO stalls ready
    assign fifo_in = {wr_addr, wdata_r, 2'b00};
    assign half = ~nonmux_select & ~full;
    // Half-word writes go out with the second half only
    assign wr_need = ~rd_r & data_acc & legal & (~half | hw_r);
    assign word_addr = {eff_addr[31:2], 2'b00};
    assign wr_addr = word_addr;
    assign wr_push = (state_r == ST_BUSY) & wr_need;
    // Second half of a half-word read reuses the word already fetched
    assign rd_hit = hw_r && (rd_addr_r == word_addr);
    assign rd_ok = !rd_pending_r && (fetched_r || rd_hit);
    assign finish = (state_r == ST_BUSY) && (state_nxt != ST_BUSY);
    assign fifo_pop = fifo_out_valid & mem_ack_in & ~rd_pending_r;
    assign mem_req_out = rd_pending_r | fifo_out_valid;
    assign mem_write_out = ~rd_pending_r;
    assign mem_addr_out = rd_pending_r ? rd_addr_r : fifo_out[65:34];
    assign mem_wdata_out = fifo_out[33:2];
    assign mem_be_out = rd_pending_r ? 4'b1111 : be_r;

    hpi_fifo #(.WIDTH(`HPI_FIFO_WIDTH), .DEPTH(`HPI_FIFO_DEPTH), .AW(2)) u_fifo (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(wr_push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(fifo_in),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(mem_ack_in & ~rd_pending_r),
        .out_data_out(fifo_out)
    );

    // Access sequencer
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if ((rise && !rd_r) || (taken_r && strobe && rd_r))
                    state_nxt = ST_BUSY;
            end
            ST_BUSY: begin
                // Writes finish on entry into the FIFO; reads on memory ack
                if (!data_acc || !legal || (rd_r ? rd_ok : (!wr_need || fifo_in_ready)))
                    state_nxt = rd_r ? ST_DONE : ST_IDLE;
            end
            ST_DONE: begin
                if (!strobe)
                    state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Ready asserted low waits while busy; release gated by chip select
    assign host_ready_n_out = host_chip_select_n_in ? 1'b1 :
        ~(state_r == ST_DONE || (state_r == ST_IDLE && !rd_pending_r && !host_rw_in));
    assign dsp_interrupt_out = port_control_reg_r[`HPI_PORT_CONTROL_REG_DSPINT];
    assign to_host_interrupt_n_out = ~port_control_reg_r[`HPI_PORT_CONTROL_REG_TO_HOST_INTERRUPT];
    // Upper lanes driven on reads unless handed to GPIO; half-word mode drives them as well
    assign host_data_bus_oe_out = (rd_r && taken_r && strobe) ?
        {upper_gpio_select_in ? 16'h0000 : 16'hFFFF, 16'hFFFF} : 32'h0000_0000;

    // Sequential state
    always @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= ST_IDLE;
            strobe_q_r <= 1'b0;
            taken_r <= 1'b0;
            fetched_r <= 1'b0;
            type_r <= 2'b00;
            hw_r <= 1'b0;
            rd_r <= 1'b0;
            be_r <= 4'h0;
            ha_r <= 16'h0000;
            addr_r <= `HPI_ADDR_RST;
            wdata_r <= `HPI_DATA_RST;
            rdata_r <= `HPI_DATA_RST;
            port_control_reg_r <= 3'b000;
            rd_pending_r <= 1'b0;
            rd_addr_r <= `HPI_ADDR_RST;
            host_data_bus_out <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            strobe_q_r <= strobe;
            taken_r <= strobe & (taken_r | fall);
            if (state_r == ST_IDLE && state_nxt == ST_BUSY)
                fetched_r <= 1'b0;
            // Latch select, type and address on the strobe fall
            if (fall) begin
                type_r <= access_type_select_in;
                hw_r <= ~nonmux_select & ~full & halfword_select_in;
                rd_r <= host_rw_in;
                // Upper enables ignored in half-word mode
                be_r <= (~nonmux_select & ~full) ? {2'b11, ~host_byte_enables_n_in[1:0]}
                    : ~host_byte_enables_n_in;
                ha_r <= host_address_lines_in;
            end
            // Write data latched on the strobe rise
            if (rise) begin
                if (~nonmux_select & ~full & ~hw_r)
                    wdata_r[15:0] <= host_data_bus_in[15:0];
                else if (~nonmux_select & ~full)
                    wdata_r[31:16] <= host_data_bus_in[15:0];
                else
                    wdata_r <= host_data_bus_in;
            end
            // Register updates when a write access finishes
            if (finish && !rd_r) begin
                case (type_r)
                    `HPI_CTL_ADDR: begin
                        if (!nonmux_select) begin
                            if (~full)
                                addr_r <= hw_r ? {wdata_r[31:16], addr_r[15:0]}
                                    : {addr_r[31:16], wdata_r[15:0]};
                            else
                                addr_r <= wdata_r;
                        end
                    end
                    `HPI_CTL_HCTL: begin
                        if (full | nonmux_select | hw_r == 1'b0) begin
                            port_control_reg_r[`HPI_PORT_CONTROL_REG_DSPINT] <= wdata_r[`HPI_PORT_CONTROL_REG_DSPINT];
                            port_control_reg_r[`HPI_PORT_CONTROL_REG_TO_HOST_INTERRUPT] <= wdata_r[`HPI_PORT_CONTROL_REG_TO_HOST_INTERRUPT];
                        end
                    end
                    default: begin
                        if (legal && type_r == `HPI_CTL_DATA_INC && (full || hw_r))
                            addr_r <= next_addr;
                    end
                endcase
            end
            // Processor raising the host interrupt wins over a host clear
            if (to_host_interrupt_set_in)
                port_control_reg_r[`HPI_PORT_CONTROL_REG_TO_HOST_INTERRUPT] <= 1'b1;
            // Read waits for posted writes to drain so it never overtakes them
            if (state_r == ST_BUSY && rd_r && data_acc && legal && !rd_pending_r
                && !fetched_r && !rd_hit && !fifo_out_valid) begin
                rd_pending_r <= 1'b1;
                rd_addr_r <= word_addr;
            end else if (rd_pending_r && mem_ack_in) begin
                rd_pending_r <= 1'b0;
                fetched_r <= 1'b1;
                rdata_r <= mem_rdata_in;
            end
            if (finish && rd_r) begin
                if (!data_acc)
                    host_data_bus_out <= (type_r == `HPI_CTL_ADDR) ?
                        (hw_r ? {16'h0000, addr_r[31:16]} : addr_r) : {29'h0, port_control_reg_r};
                else if (~nonmux_select & ~full)
                    host_data_bus_out <= hw_r ? {16'h0000, rdata_r[31:16]}
                        : {16'h0000, rdata_r[15:0]};
                else
                    host_data_bus_out <= rdata_r & {{8{rd_be[3]}}, {8{rd_be[2]}},
                        {8{rd_be[1]}}, {8{rd_be[0]}}};
                if (data_acc && type_r == `HPI_CTL_DATA_INC && legal && (full || hw_r))
                    addr_r <= next_addr;
            end
        end
    end
endmodule
`default_nettype wire

// ==== hpi_host_port_props.sv ====
// Checker for the host port pins and the internal master
`timescale 1ns/1ps
`default_nettype none
module hpi_host_port_props (
    input wire core_clk_in,
    input wire reset_n_in,
    input wire [7:0] port_config_reg_in,
    input wire [7:0] page_addr_top_byte_in,
    input wire [7:0] page_addr_upper_mid_byte_in,
    input wire upper_gpio_select_in,
    input wire to_host_interrupt_set_in,
    input wire host_chip_select_n_in,
    input wire host_rw_in,
    input wire [31:0] host_data_bus_oe_out,
    input wire host_ready_n_out,
    input wire to_host_interrupt_n_out,
    input wire mem_req_out,
    input wire mem_write_out,
    input wire [31:0] mem_addr_out,
    input wire mem_ack_in
);
    // One clock domain, so one clocking and one reset for all
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    AST_RDY_CS: assert property (host_chip_select_n_in |-> host_ready_n_out)
        else $error("ready shown without chip select");
    AST_RD_WAIT: assert property (mem_req_out && !mem_write_out && !mem_ack_in |-> host_ready_n_out)
        else $error("read ready before memory answered");
    AST_REQ_HOLD: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out) && $stable(mem_write_out))
        else $error("internal request dropped or changed early");
    AST_EN_GATE: assert property ($rose(mem_req_out) |-> port_config_reg_in[0])
        else $error("request from a disabled port");
    AST_PAGE: assert property ($rose(mem_req_out) && (port_config_reg_in[1] || port_config_reg_in[2]) |-> mem_addr_out[31:16] == {page_addr_top_byte_in, page_addr_upper_mid_byte_in})
        else $error("upper address not taken from page bytes");
    AST_GPIO: assert property (upper_gpio_select_in |-> host_data_bus_oe_out[31:16] == 16'h0000)
        else $error("upper data lines driven while kept as pins");
    AST_OE_RD: assert property (host_data_bus_oe_out != 32'h0000_0000 |-> host_rw_in)
        else $error("data lines driven outside a read");
    AST_TO_HOST_INTERRUPT: assert property (to_host_interrupt_set_in |=> !to_host_interrupt_n_out)
        else $error("host interrupt not raised");
    // Main traffic kinds seen at least once
    cover property ($rose(mem_req_out) && mem_write_out);
    cover property ($rose(mem_req_out) && !mem_write_out);
    cover property (!to_host_interrupt_n_out);
endmodule
bind hpi_host_port hpi_host_port_props u_hpi_host_port_props (
    .core_clk_in, .reset_n_in, .port_config_reg_in, .page_addr_top_byte_in,
    .page_addr_upper_mid_byte_in, .upper_gpio_select_in, .to_host_interrupt_set_in,
    .host_chip_select_n_in, .host_rw_in, .host_data_bus_oe_out, .host_ready_n_out,
    .to_host_interrupt_n_out, .mem_req_out, .mem_write_out, .mem_addr_out, .mem_ack_in
);
`default_nettype wire

// ==== hpi_mem_model.sv ====
// Behavioural memory standing behind the port's internal master
`timescale 1ns/1ps
`default_nettype none
module hpi_mem_model (
    input wire logic core_clk_in,
    input wire logic slow_in,
    input wire logic req_in,
    input wire logic write_in,
    input wire logic [31:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] be_in,
    output logic ack_out,
    output logic [31:0] rdata_out
);
    logic [31:0] mem [0:255];
    int wait_n = 0;
    initial ack_out = 1'b0;
    initial rdata_out = 32'h0000_0000;
    // Answer after one or five waits; read data toggles unless it is being answered
    always @(posedge core_clk_in) begin
        ack_out <= 1'b0;
        rdata_out <= ~rdata_out;
        if (req_in && !ack_out) begin
            if (wait_n < (slow_in ? 5 : 1)) begin
                wait_n <= wait_n + 1;
            end else begin
                wait_n <= 0;
                ack_out <= 1'b1;
                for (int i = 0; i < 4; i++)
                    if (write_in && be_in[i]) mem[addr_in[9:2]][8*i+:8] <= wdata_in[8*i+:8];
                if (!write_in) rdata_out <= mem[addr_in[9:2]];
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the host port block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'b0, rst_n = 1'b0, gpio = 1'b0, hset = 1'b0, cs_n = 1'b1;
    logic rw = 1'b0, hws = 1'b0, slow = 1'b0;
    logic [7:0] cfg = 8'h00, top = 8'h00, mid = 8'h00;
    logic [1:0] ds_n = 2'b00, typ = 2'b00;
    logic [3:0] be_n = 4'h0;
    logic [15:0] ha = 16'h0000;
    logic [31:0] din = 32'h0000_0000, q;
    wire [31:0] dq, oe, maddr, mwd, mrd;
    wire rdy_n, to_host_interrupt_n, dint, mreq, mwr, mack;
    wire [3:0] mbe;
    int failures = 0;
    int checks = 0;
    always #2.5 clk = ~clk;
    hpi_host_port u_hpi_host_port (.core_clk_in(clk), .reset_n_in(rst_n),
        .port_config_reg_in(cfg), .page_addr_top_byte_in(top),
        .page_addr_upper_mid_byte_in(mid), .upper_gpio_select_in(gpio),
        .to_host_interrupt_set_in(hset), .dsp_interrupt_out(dint),
        .host_chip_select_n_in(cs_n), .host_data_strobes_n_in(ds_n), .host_rw_in(rw),
        .host_addr_phase_n_in(1'b1),
        .access_type_select_in(typ), .halfword_select_in(hws),
        .host_byte_enables_n_in(be_n), .host_address_lines_in(ha), .host_data_bus_in(din),
        .host_data_bus_out(dq), .host_data_bus_oe_out(oe), .host_ready_n_out(rdy_n),
        .to_host_interrupt_n_out(to_host_interrupt_n), .mem_req_out(mreq), .mem_write_out(mwr),
        .mem_addr_out(maddr), .mem_wdata_out(mwd), .mem_be_out(mbe), .mem_ack_in(mack),
        .mem_rdata_in(mrd));
    hpi_mem_model u_hpi_mem_model (.core_clk_in(clk), .slow_in(slow), .req_in(mreq),
        .write_in(mwr), .addr_in(maddr), .wdata_in(mwd), .be_in(mbe), .ack_out(mack),
        .rdata_out(mrd));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One host access; request held until ready is seen, then released together
    task automatic hacc(input logic [1:0] t, input logic rd, input logic hw,
                        input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cs_n <= 1'b0;
        ds_n <= 2'b01;
        typ <= t;
        rw <= rd;
        hws <= hw;
        din <= d;
        @(negedge clk);
        while (rdy_n !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n == 200) chk("ready_n", 32'h0000_0000, 32'h0000_0001);
        r = dq;
        @(posedge clk);
        cs_n <= 1'b1;
        ds_n <= 2'b00;
        @(posedge clk);
    endtask
    // Mode bits settle before the enable bit goes up
    task automatic set_cfg(input logic [7:0] v);
        cfg <= {v[7:1], 1'b0};
        @(posedge clk);
        cfg <= v;
        @(posedge clk);
    endtask
    task automatic t_full;
        set_cfg(8'h09);
        slow <= 1'b1;
        hacc(2'b10, 1'b0, 1'b0, 32'h0000_0010, q);
        for (int i = 0; i < 6; i++) hacc(2'b01, 1'b0, 1'b0, 32'hA5A5_0000 + i, q);
        hacc(2'b10, 1'b0, 1'b0, 32'h0000_0010, q);
        for (int i = 0; i < 6; i++) begin
            hacc(2'b01, 1'b1, 1'b0, 32'h0000_0000, q);
            chk("inc_read", 32'hA5A5_0000 + i, q);
        end
        hacc(2'b10, 1'b0, 1'b0, 32'h0000_0011, q);
        hacc(2'b11, 1'b1, 1'b0, 32'h0000_0000, q);
        hacc(2'b11, 1'b1, 1'b0, 32'h0000_0000, q);
        chk("fixed_read", 32'hA5A5_0001, q);
        slow <= 1'b0;
        $display("test full done");
    endtask
    task automatic t_half;
        set_cfg(8'h01);
        gpio <= 1'b1;
        be_n <= 4'hC;
        hacc(2'b10, 1'b0, 1'b0, 32'h0000_0020, q);
        hacc(2'b10, 1'b0, 1'b1, 32'h0000_0000, q);
        hacc(2'b11, 1'b0, 1'b0, 32'h0000_1234, q);
        hacc(2'b11, 1'b0, 1'b1, 32'h0000_BEEF, q);
        hacc(2'b11, 1'b1, 1'b0, 32'h0000_0000, q);
        chk("half_lo", 32'h0000_1234, {16'h0000, q[15:0]});
        hacc(2'b11, 1'b1, 1'b1, 32'h0000_0000, q);
        chk("half_hi", 32'h0000_BEEF, {16'h0000, q[15:0]});
        gpio <= 1'b0;
        be_n <= 4'h0;
        $display("test half done");
    endtask
    task automatic t_page;
        top <= 8'h12;
        mid <= 8'h34;
        set_cfg(8'h0B);
        hacc(2'b10, 1'b0, 1'b0, 32'h0000_0030, q);
        hacc(2'b11, 1'b0, 1'b0, 32'h5A5A_0001, q);
        hacc(2'b11, 1'b1, 1'b0, 32'h0000_0000, q);
        chk("page_read", 32'h5A5A_0001, q);
        $display("test page done");
    endtask
    task automatic t_nonmux;
        set_cfg(8'h05);
        ha <= 16'h0050;
        hacc(2'b11, 1'b0, 1'b0, 32'hCAFE_0005, q);
        hacc(2'b10, 1'b0, 1'b0, 32'h0000_0000, q);
        hacc(2'b01, 1'b0, 1'b0, 32'hDEAD_0000, q);
        hacc(2'b11, 1'b1, 1'b0, 32'h0000_0000, q);
        chk("nonmux_read", 32'hCAFE_0005, q);
        $display("test nonmux done");
    endtask
    task automatic t_irq;
        set_cfg(8'h09);
        hacc(2'b00, 1'b0, 1'b0, 32'h0000_0002, q);
        for (int n = 0; n < 10 && dint !== 1'b1; n++) @(negedge clk);
        chk("dsp_int", 32'h0000_0001, {31'h0000_0000, dint});
        @(posedge clk);
        hset <= 1'b1;
        @(posedge clk);
        hset <= 1'b0;
        @(negedge clk);
        chk("host_int_n", 32'h0000_0000, {31'h0000_0000, to_host_interrupt_n});
        $display("test irq done");
    endtask
    task automatic final_report;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Watchdog far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        failures++;
        final_report;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_full;
        t_half;
        t_page;
        t_nonmux;
        t_irq;
        final_report;
    end
endmodule
`default_nettype wire
